// ---- mpw_pkg.sv ----
// Package for the three-pair motor PWM block: register map, field layouts,
// bus and pin carriers and the block's state record.
// Assumes a 32-bit classic Wishbone slave port and one 40 MHz clock.
package mpw_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADR_TB_CTRL = 8'h00;
  localparam logic [7:0] ADR_TB_CNT = 8'h04;
  localparam logic [7:0] ADR_PERIOD = 8'h08;
  localparam logic [7:0] ADR_DUTY1 = 8'h0C;
  localparam logic [7:0] ADR_DUTY2 = 8'h10;
  localparam logic [7:0] ADR_DUTY3 = 8'h14;
  localparam logic [7:0] ADR_OUT_CTRL1 = 8'h18;
  localparam logic [7:0] ADR_OUT_CTRL2 = 8'h1C;
  localparam logic [7:0] ADR_DT_CTRL = 8'h20;
  localparam logic [7:0] ADR_OVR_CTRL = 8'h24;

  // ----------------------------------------------------------------------
  // Modes and field layouts (bit 0 of each struct is the register's bit 0)
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_UPDN = 2'b10,
    MODE_DBL = 2'b11
  } mpw_mode_e;

  // Time base control: enable 15, postscale 7:4, prescale 3:2, mode 1:0.
  typedef struct packed {
    logic en;
    logic [6:0] rsv;
    logic [3:0] post;
    logic [1:0] pre;
    mpw_mode_e mode;
  } mpw_ctrl_s;

  // Dead time: pair-uses-B 17:15, per-pair 14, clock 13:12, B 11:6, A 5:0.
  typedef struct packed {
    logic [2:0] pair_b;
    logic per_pair;
    logic [1:0] clk_sel;
    logic [5:0] dt_b;
    logic [5:0] dt_a;
  } mpw_dt_s;

  // Override: values 11:6, enables 5:0; pin 2n is high, 2n+1 is low of pair n.
  typedef struct packed {
    logic [5:0] val;
    logic [5:0] ena;
  } mpw_ovr_s;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mpw_wb_req_s;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } mpw_pins_s;

  typedef struct packed {
    mpw_ctrl_s ctrl;
    logic [14:0] per_buf;
    logic [14:0] per;
    logic [14:0] cnt;
    logic dir;
    logic [2:0][15:0] duty_buf;
    logic [2:0][15:0] duty;
    logic [2:0] indep;
    logic lock;
    mpw_dt_s dt;
    mpw_ovr_s ovr;
    logic [5:0] presc;
    logic [3:0] post;
    logic [2:0] cmp;
    logic [2:0][5:0] dcnt;
    logic [2:0][2:0] dpre;
    mpw_pins_s pins;
    logic ack;
    logic [31:0] rdat;
    logic evt;
  } mpw_st_s;

  // Everything clears at reset: pairs complementary, time base stopped.
  localparam mpw_st_s ST_RST = '0;

endpackage

// ---- mpw_pwm.sv ----
// Three-pair motor PWM generator with time base, duty compare and dead time.
// Assumes a classic Wishbone master on the same clock and gate drivers on
// the pin outputs; clk_i is the instruction clock.
//
// Notes on behaviour
// - Up/down modes count up to period, then down from the next tick.
// - Counter register bit 15 reads the direction, set while counting down.
// - Mode 10 raises an event at zero turning upward, through the postscaler.
// - Mode 11 raises events at zero and at period match, no postscaler.
// - Prescaler 1, 4, 16 or 64; cleared by counter or control write, reset.
// - A control write clears the scalers but leaves the counter alone.
// - Four-bit postscaler 1 to 16, cleared like the prescaler.
// - Period double buffered; loads at reset-to-zero, at zero, or when disabled.
// - Edge aligned: active from zero, inactive when counter equals duty.
// - Edge aligned: duty zero never active, duty above period always active.
// - Center aligned: active at match going down, inactive at match going up.
// - Center aligned: duty zero never active, duty equal to period always.
// - Three 16-bit duties; with a prescaler above 1 the low bit places the edge half a tick later.
// - Edge aligned duties load at period reset, or disabled and unlocked.
// - Up/down duties load at zero, mode 11 also at match, always when disabled.
// - Duty n drives pair n; complementary when its select bit is clear.
// - Two dead times, used per edge or assigned per pair.
// - Per pair a 6-bit down counter loaded at compare edges delays turn-on.
// - Dead-time clock of 1, 2, 4 or 8 cycles; dead time is 6-bit count.
// - Dead-time prescaler cleared on load, dead-time register write and reset.
// - Independent pairs: no dead time, both pins may be on, overrides apply.
// - Mode 00 counts to period, resets next tick, event per match via postscaler.
// - Mode 01 resets after match, clears enable, one event, no postscaler.
// - Period zero stops the counter, no events, buffer held unless disabled.
`timescale 1ns/10ps

module mpw_pwm
  import mpw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire mpw_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Gate outputs and time base event
  output mpw_pins_s gate_o,
  output logic tb_event_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Last prescaler count before a time base tick.
  function automatic logic [5:0] pre_lim(input logic [1:0] sel);
    case (sel)
      2'b00: pre_lim = 6'h00;
      2'b01: pre_lim = 6'h03;
      2'b10: pre_lim = 6'h0F;
      default: pre_lim = 6'h3F;
    endcase
  endfunction

  // Prescaler counts below this value form the first half of a tick.
  function automatic logic [5:0] pre_half(input logic [1:0] sel);
    case (sel)
      2'b00: pre_half = 6'h00;
      2'b01: pre_half = 6'h02;
      2'b10: pre_half = 6'h08;
      default: pre_half = 6'h20;
    endcase
  endfunction

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    merge = res;
  endfunction

  // ----------------------------------------------------------------------
  // State and next state
  // ----------------------------------------------------------------------
  mpw_st_s st_ff;
  mpw_st_s nxt_st;
  logic hit;
  logic wr;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_dt;
  logic tick;
  logic match;
  logic zero_turn;
  logic up_dn;
  logic raw_evt;
  logic post_evt;
  logic duty_ld;
  logic [5:0] lim;
  logic [31:0] rd;

  always_comb begin
    logic [14:0] dh;
    logic act;
    logic rise;
    logic [5:0] dval;
    logic on_ok;
    dh = '0;
    act = 1'b0;
    rise = 1'b0;
    dval = '0;
    on_ok = 1'b0;
    nxt_st = st_ff;

    // Bus decode: one ack per request, raised the cycle after it is seen.
    hit = wb_req_i.cyc && wb_req_i.stb && !st_ff.ack;
    // A write lands at the edge where the master samples ack, not one edge before it.
    wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && st_ff.ack;
    wr_ctrl = wr && (wb_req_i.adr == ADR_TB_CTRL);
    wr_cnt = wr && (wb_req_i.adr == ADR_TB_CNT);
    wr_dt = wr && (wb_req_i.adr == ADR_DT_CTRL);
    nxt_st.ack = hit;
    nxt_st.evt = 1'b0;

    // Time base tick; a clearing write swallows the tick of its cycle.
    lim = pre_lim(st_ff.ctrl.pre);
    up_dn = st_ff.ctrl.mode[1];
    tick = st_ff.ctrl.en && (st_ff.per != '0) && !wr_ctrl && !wr_cnt
           && (st_ff.presc == lim);
    if (wr_ctrl || wr_cnt || tick) begin
      nxt_st.presc = '0;
    end else if (st_ff.ctrl.en) begin
      nxt_st.presc = st_ff.presc + 6'h01;
    end
    // A direction left over from an up/down run must not block an edge-mode match.
    match = tick && !(up_dn && st_ff.dir) && (st_ff.cnt >= st_ff.per);
    zero_turn = tick && up_dn && st_ff.dir && (st_ff.cnt == '0);

    // Counter and direction.
    if (tick) begin
      if (!up_dn) begin
        nxt_st.dir = 1'b0;
        nxt_st.cnt = match ? '0 : st_ff.cnt + 15'h0001;
      end else if (st_ff.dir) begin
        if (st_ff.cnt == '0) begin
          nxt_st.dir = 1'b0;
          nxt_st.cnt = 15'h0001;
        end else begin
          nxt_st.cnt = st_ff.cnt - 15'h0001;
        end
      end else if (match) begin
        nxt_st.dir = 1'b1;
        nxt_st.cnt = st_ff.cnt - 15'h0001;
      end else begin
        nxt_st.cnt = st_ff.cnt + 15'h0001;
      end
    end

    // Event sources per mode; single-shot also halts the time base.
    raw_evt = 1'b0;
    post_evt = 1'b0;
    unique case (st_ff.ctrl.mode)
      MODE_FREE: post_evt = match;
      MODE_SINGLE: begin
        raw_evt = match;
        if (match) begin
          nxt_st.ctrl.en = 1'b0;
        end
      end
      MODE_UPDN: post_evt = zero_turn;
      MODE_DBL: raw_evt = zero_turn || match;
    endcase
    if (wr_ctrl || wr_cnt) begin
      nxt_st.post = '0;
    end else if (post_evt) begin
      if (st_ff.post == st_ff.ctrl.post) begin
        nxt_st.post = '0;
        nxt_st.evt = 1'b1;
      end else begin
        nxt_st.post = st_ff.post + 4'h1;
      end
    end
    if (raw_evt) begin
      nxt_st.evt = 1'b1;
    end

    // Buffer transfers. Lockout also holds the running period.
    if (!st_ff.ctrl.en || (!st_ff.lock && (up_dn ? zero_turn : match))) begin
      nxt_st.per = st_ff.per_buf;
    end
    duty_ld = (!st_ff.ctrl.en && (up_dn || !st_ff.lock))
              || (!st_ff.lock && (up_dn ? (zero_turn || (st_ff.ctrl.mode == MODE_DBL
              && match)) : match));
    if (duty_ld) begin
      nxt_st.duty = st_ff.duty_buf;
    end

    // Compare, dead time and pin drive for each pair.
    for (int i = 0; i < 3; i++) begin
      dh = st_ff.duty[i][15:1];
      act = (st_ff.cnt < dh) || ((st_ff.cnt == dh) && st_ff.duty[i][0]
            && (st_ff.presc < pre_half(st_ff.ctrl.pre)));
      if (up_dn) begin
        // Going down, the match count itself is already active.
        act = act || ((dh != '0) && (st_ff.cnt == dh) && st_ff.dir);
        act = act || ((dh != '0) && (dh >= st_ff.per));
      end else begin
        act = act || (dh > st_ff.per);
      end
      nxt_st.cmp[i] = act;
      rise = act && !st_ff.cmp[i];
      dval = (st_ff.dt.per_pair ? st_ff.dt.pair_b[i] : !rise) ? st_ff.dt.dt_b
             : st_ff.dt.dt_a;
      if (act != st_ff.cmp[i]) begin
        nxt_st.dcnt[i] = dval;
        nxt_st.dpre[i] = '0;
      end else if (wr_dt) begin
        nxt_st.dpre[i] = '0;
      end else if (st_ff.dcnt[i] != '0) begin
        if (st_ff.dpre[i] == ((3'h1 << st_ff.dt.clk_sel) - 3'h1)) begin
          nxt_st.dpre[i] = '0;
          nxt_st.dcnt[i] = st_ff.dcnt[i] - 6'h01;
        end else begin
          nxt_st.dpre[i] = st_ff.dpre[i] + 3'h1;
        end
      end
      on_ok = (nxt_st.dcnt[i] == '0);
      if (st_ff.indep[i]) begin
        nxt_st.pins.high[i] = act;
        nxt_st.pins.low[i] = act;
      end else begin
        nxt_st.pins.high[i] = act && on_ok;
        nxt_st.pins.low[i] = !act && on_ok;
      end
      if (st_ff.ovr.ena[2*i]) begin
        nxt_st.pins.high[i] = st_ff.ovr.val[2*i];
      end
      if (st_ff.ovr.ena[2*i+1]) begin
        nxt_st.pins.low[i] = st_ff.ovr.val[2*i+1];
      end
    end

    // Register reads; unmapped offsets answer zero.
    case (wb_req_i.adr)
      ADR_TB_CTRL: rd = {16'h0000, st_ff.ctrl};
      ADR_TB_CNT: rd = {16'h0000, st_ff.dir, st_ff.cnt};
      ADR_PERIOD: rd = {17'h0_0000, st_ff.per_buf};
      ADR_DUTY1: rd = {16'h0000, st_ff.duty_buf[0]};
      ADR_DUTY2: rd = {16'h0000, st_ff.duty_buf[1]};
      ADR_DUTY3: rd = {16'h0000, st_ff.duty_buf[2]};
      ADR_OUT_CTRL1: rd = {29'h0000_0000, st_ff.indep};
      ADR_OUT_CTRL2: rd = {31'h0000_0000, st_ff.lock};
      ADR_DT_CTRL: rd = {14'h0000, st_ff.dt};
      ADR_OVR_CTRL: rd = {20'h0_0000, st_ff.ovr};
      default: rd = 32'h0000_0000;
    endcase
    nxt_st.rdat = (hit && !wb_req_i.we) ? rd : 32'h0000_0000;

    // Register writes come last so software wins over the single-shot clear.
    if (wr) begin
      case (wb_req_i.adr)
        ADR_TB_CTRL: nxt_st.ctrl = 16'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_TB_CNT: nxt_st.cnt = 15'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_PERIOD: nxt_st.per_buf = 15'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_DUTY1: nxt_st.duty_buf[0] = 16'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_DUTY2: nxt_st.duty_buf[1] = 16'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_DUTY3: nxt_st.duty_buf[2] = 16'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_OUT_CTRL1: nxt_st.indep = 3'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_OUT_CTRL2: nxt_st.lock = wb_req_i.sel[0] ? wb_req_i.dat[0] : st_ff.lock;
        ADR_DT_CTRL: nxt_st.dt = 18'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        ADR_OVR_CTRL: nxt_st.ovr = 12'(merge(rd, wb_req_i.dat, wb_req_i.sel));
        default: ;
      endcase
    end
  end

  // Single state register; synchronous reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a field of the state register.
  assign wb_dat_o = st_ff.rdat;
  assign wb_ack_o = st_ff.ack;
  assign gate_o = st_ff.pins;
  assign tb_event_o = st_ff.evt;

  // ----------------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  turn_down_a: assert property (tick && up_dn && match |=> st_ff.dir)
    else $error("Up/down count did not turn down at period match.");
  dir_read_a: assert property (hit && !wb_req_i.we && wb_req_i.adr == ADR_TB_CNT
    |=> wb_dat_o[15] == $past(st_ff.dir))
    else $error("Direction flag read back wrong.");
  updn_event_a: assert property (zero_turn && st_ff.ctrl.mode == MODE_UPDN
    && st_ff.ctrl.post == 4'h0 && !wr_ctrl |=> tb_event_o)
    else $error("Up/down zero event missing.");
  dbl_event_a: assert property (st_ff.ctrl.mode == MODE_DBL && (match || zero_turn)
    |=> tb_event_o)
    else $error("Double update event missing.");
  shot_stop_a: assert property (st_ff.ctrl.mode == MODE_SINGLE && match && !wr
    |=> !st_ff.ctrl.en && st_ff.cnt == '0 ##1 !tb_event_o)
    else $error("Single shot did not halt once.");
  ctrl_keep_a: assert property (wr_ctrl |=> $stable(st_ff.cnt) && st_ff.presc == '0
    && st_ff.post == '0)
    else $error("Control write disturbed the counter.");
  zero_period_a: assert property (st_ff.per == '0 && !wr |=> $stable(st_ff.cnt)
    && !tb_event_o)
    else $error("Zero period did not stop the time base.");
  no_shoot_a: assert property (!st_ff.indep[0] && st_ff.ovr.ena[1:0] == 2'b00
    |=> !(gate_o.high[0] && gate_o.low[0]))
    else $error("Complementary pair drove both gates.");
  dead_hold_a: assert property (!st_ff.indep[0] && st_ff.ovr.ena[0] == 1'b0
    && nxt_st.cmp[0] && !st_ff.cmp[0] && nxt_st.dcnt[0] != '0 |=> !gate_o.high[0])
    else $error("High gate turned on inside dead time.");
  duty_zero_a: assert property (st_ff.duty[0] == '0 |=> !st_ff.cmp[0])
    else $error("Zero duty produced an active compare.");
  edge_start_a: assert property (!up_dn && st_ff.duty[1][15:1] != '0 && st_ff.cnt == '0
    |=> st_ff.cmp[1])
    else $error("Edge-aligned output not active at period start.");
  center_match_a: assert property (up_dn && st_ff.dir && st_ff.duty[1][15:1] != '0
    && st_ff.cnt == st_ff.duty[1][15:1] |=> st_ff.cmp[1])
    else $error("Center-aligned output not active at down match.");

  updn_run_c: cover property (st_ff.ctrl.mode == MODE_UPDN && zero_turn ##[1:300] tb_event_o);
  shot_end_c: cover property (st_ff.ctrl.mode == MODE_SINGLE && match);
  dead_load_c: cover property (nxt_st.dcnt[1] != '0 && st_ff.dcnt[1] == '0);
  indep_both_c: cover property (st_ff.indep[2] && gate_o.high[2] && gate_o.low[2]);
  center_on_c: cover property (up_dn && st_ff.dir && gate_o.high[1]);

endmodule

// ---- mpw_gate_drv.sv ----
// Behavioural load for the three bridge legs driven by the motor PWM block.
// Assumes the bench tells it which pairs run independently.
`timescale 1ns/10ps

module mpw_gate_drv
  import mpw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Gate drives and pair modes
  input wire mpw_pins_s gate_i,
  input wire logic [2:0] indep_i,
  // Bridge status
  output logic shoot_o
);
  // A complementary leg with both switches on shorts the supply, so it is latched.
  // Independent legs drive separate loads and may have both pins on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shoot_o <= 1'b0;
    end else if (|(gate_i.high & gate_i.low & ~indep_i)) begin
      shoot_o <= 1'b1;
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the motor PWM block with a bridge load model.
// Assumes one 40 MHz clock and a classic Wishbone slave that acks once.
`timescale 1ns/10ps
`define MPW_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end

module tb_top;
  import mpw_pkg::*;
  logic clk_i;
  logic rst_i;
  mpw_wb_req_s req;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic ack;
  logic ev_o;
  logic shoot;
  mpw_pins_s gate;
  int err_total;
  int samples_checked;
  int ev;
  int hi[3];
  int lo[3];

  // ----------------------------------------
  // Design, bridge load and clock
  // ----------------------------------------
  mpw_pwm mpw_pwm_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .gate_o(gate), .tb_event_o(ev_o));
  // Pair 3 is set independent by every cfg call, so from t_free on it matches the load's fixed pair modes.
  mpw_gate_drv mpw_gate_drv_i (.clk_i(clk_i), .rst_i(rst_i), .gate_i(gate),
    .indep_i(3'b100), .shoot_o(shoot));

  // The clock runs at 40 MHz.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 16) begin
      err_total++;
      wrap_up();
    end
    q = dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask

  // Counts events and active gate cycles over a window.
  task automatic run(input int n);
    ev = 0;
    hi = '{0, 0, 0};
    lo = '{0, 0, 0};
    repeat (n) begin
      @(posedge clk_i);
      ev += int'(ev_o === 1'b1);
      for (int k = 0; k < 3; k++) begin
        hi[k] += int'(gate.high[k] === 1'b1);
        lo[k] += int'(gate.low[k] === 1'b1);
      end
    end
  endtask

  // Stops the time base before touching period, duties or dead time.
  task automatic cfg(input logic [31:0] c, p, d1, d2, d3, t);
    bus(1'b1, ADR_TB_CTRL, 32'h0000_0000);
    bus(1'b1, ADR_PERIOD, p);
    bus(1'b1, ADR_DUTY1, d1);
    bus(1'b1, ADR_DUTY2, d2);
    bus(1'b1, ADR_DUTY3, d3);
    bus(1'b1, ADR_OUT_CTRL1, 32'h0000_0004);
    bus(1'b1, ADR_DT_CTRL, t);
    bus(1'b1, ADR_TB_CTRL, c);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `MPW_CHK(gate, 6'h00)
    `MPW_CHK(ev_o, 1'b0)
    bus(1'b0, ADR_TB_CTRL, 32'h0000_0000);
    `MPW_CHK(q, 32'h0000_0000)
    bus(1'b1, 8'h28, 32'hffff_ffff);
    bus(1'b0, 8'h28, 32'h0000_0000);
    `MPW_CHK(q, 32'h0000_0000)
  endtask

  task automatic t_counter();
    bus(1'b1, ADR_TB_CNT, 32'h0000_0005);
    bus(1'b1, ADR_TB_CTRL, 32'h0000_0004);
    bus(1'b0, ADR_TB_CNT, 32'h0000_0000);
    `MPW_CHK(q, 32'h0000_0005)
    bus(1'b1, ADR_TB_CNT, 32'h0000_0000);
  endtask

  task automatic t_free();
    cfg(32'h0000_8000, 32'h0000_0003, 0, 0, 0, 0);
    run(24);
    run(40);
    `MPW_CHK(ev, 10)
    cfg(32'h0000_8010, 32'h0000_0003, 0, 0, 0, 0);
    run(24);
    run(40);
    `MPW_CHK(ev, 5)
    cfg(32'h0000_8004, 32'h0000_0003, 0, 0, 0, 0);
    run(24);
    run(64);
    `MPW_CHK(ev, 4)
  endtask

  task automatic t_single();
    cfg(32'h0000_8011, 32'h0000_0003, 0, 0, 0, 0);
    run(40);
    `MPW_CHK(ev, 1)
    bus(1'b0, ADR_TB_CTRL, 32'h0000_0000);
    `MPW_CHK(q, 32'h0000_0011)
    cfg(32'h0000_8000, 32'h0000_0000, 0, 0, 0, 0);
    run(40);
    `MPW_CHK(ev, 0)
  endtask

  // Center aligned; the period stays above one in double-update mode.
  task automatic t_center();
    logic sd;
    logic su;
    sd = 1'b0;
    su = 1'b0;
    cfg(32'h0000_8002, 32'h0000_0003, 0, 32'h0000_0004, 32'h0000_0006, 0);
    run(24);
    run(60);
    `MPW_CHK(ev, 10)
    `MPW_CHK({hi[0], hi[1], hi[2]}, {32'd0, 32'd40, 32'd60})
    `MPW_CHK({lo[0], lo[1], lo[2]}, {32'd60, 32'd20, 32'd60})
    repeat (6) begin
      bus(1'b0, ADR_TB_CNT, 32'h0000_0000);
      sd |= q[15];
      su |= ~q[15];
    end
    `MPW_CHK({sd, su}, 2'b11)
    cfg(32'h0000_8003, 32'h0000_0003, 0, 32'h0000_0004, 32'h0000_0006, 0);
    run(24);
    run(60);
    `MPW_CHK(ev, 20)
    `MPW_CHK(hi[1], 40)
  endtask

  task automatic t_edge();
    cfg(32'h0000_8000, 32'h0000_0007, 0, 32'h0000_0006, 32'h0000_0010, 0);
    run(24);
    run(80);
    `MPW_CHK({hi[0], hi[1], hi[2]}, {32'd0, 32'd30, 32'd80})
    `MPW_CHK({lo[0], lo[1], lo[2]}, {32'd80, 32'd50, 32'd80})
  endtask

  // Per-edge dead time, then the two-cycle dead-time clock.
  task automatic t_dead();
    cfg(32'h0000_8000, 32'h0000_0007, 32'h0000_0008, 0, 32'h0000_0008, 32'h0000_0042);
    run(24);
    run(80);
    `MPW_CHK({hi[0], lo[0]}, {32'd20, 32'd30})
    `MPW_CHK({hi[2], lo[2]}, {32'd40, 32'd40})
    cfg(32'h0000_8000, 32'h0000_0007, 32'h0000_0008, 0, 32'h0000_0008, 32'h0000_1041);
    run(24);
    run(80);
    `MPW_CHK({hi[0], lo[0]}, {32'd20, 32'd20})
    `MPW_CHK(shoot, 1'b0)
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    req = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_counter();
    t_free();
    t_single();
    t_center();
    t_edge();
    t_dead();
    wrap_up();
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end
endmodule
